// ### shared/iosi_consts.vh
// register map, field positions, reset values and timing counts of the slave interrupt block
`ifndef IOSI_CONSTS_VH
`define IOSI_CONSTS_VH

// byte addresses of the registers
`define IOSI_ADDR_FLAGS        32'h00010500
`define IOSI_ADDR_ENABLES      32'h00010504
`define IOSI_ADDR_ACK_COUNT    32'h00010508
`define IOSI_ADDR_WIN_CTRL     32'h0001040c

// flag and enable bit positions
`define IOSI_BIT_READ_UNMAPPED  0
`define IOSI_BIT_WRITE_UNMAPPED 1
`define IOSI_BIT_BAD_BURST      2
`define IOSI_BIT_BAD_LANES      3
`define IOSI_BIT_ACK_DRAINED    4
`define IOSI_NUM_FLAGS          5

// window control field positions
`define IOSI_BIT_ACK_WRITE_SEL    0
`define IOSI_BIT_STREAM_WRITE_SEL 1

// reset values
`define IOSI_FLAGS_RESET     5'h00
`define IOSI_ENABLES_RESET   5'h00
`define IOSI_COUNT_RESET     5'h00
`define IOSI_WIN_CTRL_RESET  2'h0

// widths
`define IOSI_COUNT_W     5
`define IOSI_BURST_W     8
`define IOSI_LANES_W     4

// cycles between an acknowledged write start and its count update (at most 8)
`define IOSI_ACK_LAG     4

// bus encodings
`define IOSI_HTRANS_NONSEQ 2'h2
`define IOSI_HRESP_OKAY    1'b0

`endif

// ### test/iosi_asserts.sv
// port checks for the slave interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "iosi_consts.vh"
module iosi_asserts (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic        hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic        hreadyout_o,
    input wire logic        hresp_o,
    input wire logic        irq_o,
    input wire logic        ack_write_select_o,
    input wire logic        stream_write_select_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire take = hsel_i && hready_i && htrans_i == `IOSI_HTRANS_NONSEQ;
    sequence s_rd_wait;
        !hreadyout_o ##1 hreadyout_o;
    endsequence
    sequence s_ctrl_both;
        take && hwrite_i && haddr_i == `IOSI_ADDR_WIN_CTRL ##1 hwdata_i[1:0] == 2'h3;
    endsequence
    a_resp_okay: assert property (hresp_o == `IOSI_HRESP_OKAY)
        else $error("response not okay");
    a_read_wait: assert property (take && !hwrite_i |=> s_rd_wait)
        else $error("read wait state wrong");
    a_write_nowait: assert property (take && hwrite_i |=> hreadyout_o)
        else $error("write stalled");
    a_read_upper_zero: assert property (take && !hwrite_i |=>
        ##1 hrdata_o[31:5] == 27'h0)
        else $error("upper read bits set");
    a_sel_exclusive: assert property (!(ack_write_select_o && stream_write_select_o))
        else $error("both selects set");
    a_sel_both_kept: assert property (s_ctrl_both |=>
        $stable({ack_write_select_o, stream_write_select_o}))
        else $error("selects changed");
    a_irq_reset_low: assert property ($past(rst_i) |-> !irq_o)
        else $error("irq after reset");
    a_sel_reset_low: assert property ($past(rst_i) |->
        !ack_write_select_o && !stream_write_select_o)
        else $error("select after reset");
endmodule // iosi_asserts
bind iosi_top iosi_asserts chk_u (.clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .irq_o, .ack_write_select_o,
    .stream_write_select_o);
`default_nettype wire

// ### test/iosi_evt_master.sv
// event source standing in for the slave port bus master
`timescale 1ns/1ps
`default_nettype none
module iosi_evt_master (
    input  wire logic  clk_i,
    output logic       wr_start_o,
    output logic [7:0] wr_len_o,
    output logic       wr_hit_o,
    output logic       wr_beat_o,
    output logic [3:0] wr_be_o,
    output logic       rd_start_o,
    output logic       rd_hit_o,
    output logic       ack_start_o,
    output logic       ack_done_o
);
    initial begin
        {wr_start_o, wr_beat_o, rd_start_o, ack_start_o, ack_done_o} = 5'h0;
        {wr_len_o, wr_hit_o, wr_be_o, rd_hit_o} = 14'h0;
    end
    task automatic wr_burst(input logic [7:0] n, input logic hit, input logic [3:0] be);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            wr_start_o <= (i == 0);
            wr_len_o <= n;
            wr_hit_o <= hit;
            wr_beat_o <= 1'b1;
            wr_be_o <= be;
        end
        @(posedge clk_i);
        // released qualifiers show the inverse
        wr_start_o <= 1'b0;
        wr_beat_o <= 1'b0;
        wr_len_o <= ~n;
        wr_hit_o <= ~hit;
        wr_be_o <= ~be;
    endtask
    task automatic rd_req(input logic hit);
        @(posedge clk_i);
        rd_start_o <= 1'b1;
        rd_hit_o <= hit;
        @(posedge clk_i);
        rd_start_o <= 1'b0;
        rd_hit_o <= ~hit;
    endtask
    task automatic ack(input logic s, input logic d);
        @(posedge clk_i);
        ack_start_o <= s;
        ack_done_o <= d;
        @(posedge clk_i);
        ack_start_o <= 1'b0;
        ack_done_o <= 1'b0;
    endtask
endmodule // iosi_evt_master
`default_nettype wire

// ### test/tb_iosi_top.sv
// self-checking bench for the slave interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "iosi_consts.vh"
`define CHK(a, e, m) begin comparisons++; if ((a) !== (e)) begin fails++; \
    $display("unexpected at %0t: %s", $time, m); end end
module tb_iosi_top;
    logic        clk_i = 0, rst_i = 1, hsel_i = 0, hwrite_i = 0;
    logic [31:0] haddr_i = 0, hwdata_i = 0;
    logic [1:0]  htrans_i = 0;
    wire  [31:0] hrdata_o;
    wire  [7:0]  wr_len;
    wire  [3:0]  wr_be;
    wire         hreadyout_o, irq_o, ack_sel, str_sel, wr_start, wr_hit, wr_beat;
    wire         rd_start, rd_hit, ack_s, ack_d;
    int          fails = 0, comparisons = 0;
    iosi_top dut_u (.clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2),
        .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o(),
        .wr_start_i(wr_start), .wr_burstcount_i(wr_len), .wr_hit_i(wr_hit),
        .wr_beat_i(wr_beat), .wr_byteenable_i(wr_be), .rd_start_i(rd_start),
        .rd_hit_i(rd_hit), .ack_write_start_i(ack_s), .ack_write_done_i(ack_d), .irq_o,
        .ack_write_select_o(ack_sel), .stream_write_select_o(str_sel));
    iosi_evt_master em (.clk_i, .wr_start_o(wr_start), .wr_len_o(wr_len), .wr_hit_o(wr_hit),
        .wr_beat_o(wr_beat), .wr_be_o(wr_be), .rd_start_o(rd_start), .rd_hit_o(rd_hit),
        .ack_start_o(ack_s), .ack_done_o(ack_d));
    initial forever #12.5 clk_i = ~clk_i;
    task automatic end_sim;
        if (fails == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
        hsel_i <= 1'b1;
        haddr_i <= a;
        hwrite_i <= w;
        htrans_i <= `IOSI_HTRANS_NONSEQ;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        r = hrdata_o;
    endtask
    task automatic wr(input logic [31:0] a, d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [31:0] a, e, input string m);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        `CHK(r, e, m)
    endtask
    task automatic t_regs;
        rd(`IOSI_ADDR_FLAGS, 32'h10, "flags reset");
        rd(`IOSI_ADDR_ENABLES, 32'h0, "enables reset");
        wr(`IOSI_ADDR_ENABLES, 32'hffffffff);
        rd(`IOSI_ADDR_ENABLES, 32'h1f, "enables rw");
        wr(`IOSI_ADDR_ENABLES, 32'h0);
        wr(`IOSI_ADDR_ACK_COUNT, 32'h7);
        rd(`IOSI_ADDR_ACK_COUNT, 32'h0, "count ro");
        rd(32'h00010514, 32'h0, "unmapped");
    endtask
    task automatic t_flags;
        logic [31:0] x;
        for (int i = 0; i < 6; i++) begin
            wr(`IOSI_ADDR_FLAGS, 32'hf);
            case (i)
                0: em.rd_req(1'b0);
                1: em.wr_burst(8'h1, 1'b0, 4'hf);
                2: em.wr_burst(8'h3, 1'b1, 4'hf);
                3: em.wr_burst(8'h2, 1'b1, 4'h5);
                4: em.wr_burst(8'h1, 1'b1, 4'h3);
                default: em.rd_req(1'b1);
            endcase
            x = 32'h10 | (i < 4 ? 32'h1 << i : 32'h0);
            rd(`IOSI_ADDR_FLAGS, x, "flag");
        end
    endtask
    task automatic t_irq;
        wr(`IOSI_ADDR_ENABLES, 32'h1);
        em.rd_req(1'b0);
        repeat (2) @(posedge clk_i);
        `CHK(irq_o, 1'b1, "irq high")
        wr(`IOSI_ADDR_ENABLES, 32'h2);
        repeat (2) @(posedge clk_i);
        `CHK(irq_o, 1'b0, "irq masked")
        wr(`IOSI_ADDR_ENABLES, 32'h1);
        wr(`IOSI_ADDR_FLAGS, 32'h1);
        repeat (2) @(posedge clk_i);
        `CHK(irq_o, 1'b0, "irq cleared")
        fork
            wr(`IOSI_ADDR_FLAGS, 32'h1);
            em.rd_req(1'b0);
        join
        rd(`IOSI_ADDR_FLAGS, 32'h11, "set over clear");
    endtask
    task automatic t_count;
        em.ack(1'b1, 1'b0);
        repeat (8) @(posedge clk_i);
        rd(`IOSI_ADDR_ACK_COUNT, 32'h1, "count up");
        // software clears and enables the drained interrupt only after the wait
        wr(`IOSI_ADDR_FLAGS, 32'h1f);
        wr(`IOSI_ADDR_ENABLES, 32'h10);
        rd(`IOSI_ADDR_FLAGS, 32'h0, "drained clear");
        `CHK(irq_o, 1'b0, "irq idle")
        em.ack(1'b0, 1'b1);
        rd(`IOSI_ADDR_FLAGS, 32'h10, "drained set");
        `CHK(irq_o, 1'b1, "irq drained")
    endtask
    task automatic t_sel;
        logic [1:0] s[4] = '{2'h1, 2'h3, 2'h2, 2'h3};
        logic [1:0] e;
        for (int i = 0; i < 4; i++) begin
            if (s[i] != 2'h3)
                e = s[i];
            wr(`IOSI_ADDR_WIN_CTRL, {30'h0, s[i]});
            rd(`IOSI_ADDR_WIN_CTRL, {30'h0, e}, "select reg");
            `CHK({str_sel, ack_sel}, e, "select out")
        end
        rst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`IOSI_ADDR_WIN_CTRL, 32'h0, "select reset");
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs;
        t_flags;
        t_irq;
        t_count;
        t_sel;
        end_sim;
    end
    initial begin
        #(25 * 4000);
        fails++;
        end_sim;
    end
endmodule // tb_iosi_top
`default_nettype wire

// ### verilog/iosi_ack_count.v
// outstanding acknowledged-write counter with a fixed start-to-count lag
`timescale 1ns/1ps
`default_nettype none
`include "iosi_consts.vh"

module iosi_ack_count (
    input  wire                       clk_i,
    input  wire                       rst_i,
    input  wire                       start_i,
    input  wire                       done_i,
    output reg  [`IOSI_COUNT_W-1:0]   count_o
);

    reg  [`IOSI_ACK_LAG-1:0] lag_q;
    wire                     inc;
    wire                     dec;

    // start pulses travel through a short delay line before counting
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            lag_q <= {`IOSI_ACK_LAG{1'b0}};
        end else begin
            lag_q <= {lag_q[`IOSI_ACK_LAG-2:0], start_i};
        end
    end

    assign inc = lag_q[`IOSI_ACK_LAG-1] & (count_o != {`IOSI_COUNT_W{1'b1}});
    assign dec = done_i & (count_o != `IOSI_COUNT_RESET);

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_o <= `IOSI_COUNT_RESET;
        end else if (inc & ~dec) begin
            count_o <= count_o + 5'h01;
        end else if (dec & ~inc) begin
            count_o <= count_o - 5'h01;
        end
    end

endmodule // iosi_ack_count

`default_nettype wire

// ### verilog/iosi_top.v
// io slave interrupt status, enables, outstanding write count, ahb-lite registers
`timescale 1ns/1ps
`default_nettype none
`include "iosi_consts.vh"

module iosi_top (
    input  wire                      clk_i,
    input  wire                      rst_i,
    // ahb-lite slave
    input  wire                      hsel_i,
    input  wire [31:0]               haddr_i,
    input  wire [1:0]                htrans_i,
    input  wire                      hwrite_i,
    input  wire [2:0]                hsize_i,
    input  wire [31:0]               hwdata_i,
    input  wire                      hready_i,
    output wire [31:0]               hrdata_o,
    output wire                      hreadyout_o,
    output wire                      hresp_o,
    // events from the slave port logic, same clock
    input  wire                      wr_start_i,
    input  wire [`IOSI_BURST_W-1:0]  wr_burstcount_i,
    input  wire                      wr_hit_i,
    input  wire                      wr_beat_i,
    input  wire [`IOSI_LANES_W-1:0]  wr_byteenable_i,
    input  wire                      rd_start_i,
    input  wire                      rd_hit_i,
    input  wire                      ack_write_start_i,
    input  wire                      ack_write_done_i,
    // outputs
    output wire                      irq_o,
    output wire                      ack_write_select_o,
    output wire                      stream_write_select_o
);

    // byte-lane patterns accepted on a 32-bit write path
    function lanes_ok;
        input [`IOSI_LANES_W-1:0] be;
        begin
            case (be)
                4'hf, 4'h3, 4'hc, 4'h1, 4'h2, 4'h4, 4'h8: lanes_ok = 1'b1;
                default:                                 lanes_ok = 1'b0;
            endcase
        end
    endfunction

    // word decode, used by both write and read paths
    function [1:0] reg_sel;
        input [31:0] a;
        begin
            case (a)
                `IOSI_ADDR_FLAGS:     reg_sel = 2'h0;
                `IOSI_ADDR_ENABLES:   reg_sel = 2'h1;
                `IOSI_ADDR_ACK_COUNT: reg_sel = 2'h2;
                `IOSI_ADDR_WIN_CTRL:  reg_sel = 2'h3;
                default:              reg_sel = 2'h0;
            endcase
        end
    endfunction

    function mapped;
        input [31:0] a;
        begin
            mapped = (a == `IOSI_ADDR_FLAGS) || (a == `IOSI_ADDR_ENABLES) ||
                     (a == `IOSI_ADDR_ACK_COUNT) || (a == `IOSI_ADDR_WIN_CTRL);
        end
    endfunction

    localparam SEL_FLAGS   = 2'h0;
    localparam SEL_ENABLES = 2'h1;
    localparam SEL_COUNT   = 2'h2;
    localparam SEL_WIN     = 2'h3;

    reg  [31:0]                     dp_addr_q;
    reg                             dp_wr_q;
    reg                             rd_busy_q;
    reg  [31:0]                     hrdata_q;
    reg  [`IOSI_NUM_FLAGS-1:0]      flags_q;
    reg  [`IOSI_NUM_FLAGS-1:0]      enables_q;
    reg  [1:0]                      win_ctrl_q;
    reg                             irq_q;
    reg  [31:0]                     rdata_d;
    wire                            accept;
    wire                            wr_now;
    wire [1:0]                      wr_sel;
    wire [`IOSI_COUNT_W-1:0]        ack_count;
    wire [`IOSI_NUM_FLAGS-1:0]      set_vec;
    wire [`IOSI_NUM_FLAGS-1:0]      clr_vec;
    wire                            burst_bad;

    // address phase taken when selected, ready and nonseq
    assign accept = hsel_i & hready_i & (htrans_i == `IOSI_HTRANS_NONSEQ);

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dp_addr_q <= 32'h00000000;
            dp_wr_q   <= 1'b0;
            rd_busy_q <= 1'b0;
        end else begin
            if (hready_i) begin
                dp_wr_q <= accept & hwrite_i;
                if (accept) begin
                    dp_addr_q <= haddr_i;
                end
            end
            if (rd_busy_q) begin
                rd_busy_q <= 1'b0;
            end else begin
                rd_busy_q <= accept & ~hwrite_i;
            end
        end
    end

    // reads take one wait state so a write just before is visible
    assign hreadyout_o = ~rd_busy_q;
    assign hresp_o     = `IOSI_HRESP_OKAY;
    assign hrdata_o    = hrdata_q;

    assign wr_now = dp_wr_q & mapped(dp_addr_q);
    assign wr_sel = reg_sel(dp_addr_q);

    always @* begin
        rdata_d = 32'h00000000;
        if (mapped(dp_addr_q)) begin
            case (reg_sel(dp_addr_q))
                SEL_FLAGS:   rdata_d[`IOSI_NUM_FLAGS-1:0] = flags_q;
                SEL_ENABLES: rdata_d[`IOSI_NUM_FLAGS-1:0] = enables_q;
                SEL_COUNT:   rdata_d[`IOSI_COUNT_W-1:0]   = ack_count;
                SEL_WIN:     rdata_d[1:0]                 = win_ctrl_q;
                default:     rdata_d = 32'h00000000;
            endcase
        end
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hrdata_q <= 32'h00000000;
        end else if (rd_busy_q) begin
            hrdata_q <= rdata_d;
        end
    end

    // enable register
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            enables_q <= `IOSI_ENABLES_RESET;
        end else if (wr_now && wr_sel == SEL_ENABLES) begin
            enables_q <= hwdata_i[`IOSI_NUM_FLAGS-1:0];
        end
    end

    // window control: both selects at once leaves the field unchanged
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            win_ctrl_q <= `IOSI_WIN_CTRL_RESET;
        end else if (wr_now && wr_sel == SEL_WIN && hwdata_i[1:0] != 2'h3) begin
            win_ctrl_q <= hwdata_i[1:0];
        end
    end

    assign ack_write_select_o    = win_ctrl_q[`IOSI_BIT_ACK_WRITE_SEL];
    assign stream_write_select_o = win_ctrl_q[`IOSI_BIT_STREAM_WRITE_SEL];

    iosi_ack_count u_ack_count (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .start_i (ack_write_start_i),
        .done_i  (ack_write_done_i),
        .count_o (ack_count)
    );

    // event conditions
    assign burst_bad = wr_burstcount_i[0] & (wr_burstcount_i != 8'h01);

    assign set_vec[`IOSI_BIT_ACK_DRAINED]    = (ack_count == `IOSI_COUNT_RESET);
    assign set_vec[`IOSI_BIT_BAD_LANES]      = wr_beat_i & ~lanes_ok(wr_byteenable_i);
    assign set_vec[`IOSI_BIT_BAD_BURST]      = wr_start_i & burst_bad;
    assign set_vec[`IOSI_BIT_WRITE_UNMAPPED] = wr_start_i & ~wr_hit_i;
    assign set_vec[`IOSI_BIT_READ_UNMAPPED]  = rd_start_i & ~rd_hit_i;

    assign clr_vec = (wr_now && wr_sel == SEL_FLAGS) ? hwdata_i[`IOSI_NUM_FLAGS-1:0]
                                                     : {`IOSI_NUM_FLAGS{1'b0}};

    // sticky write-one-to-clear flags
    genvar gi;
    generate
        for (gi = 0; gi < `IOSI_NUM_FLAGS; gi = gi + 1) begin : g_flag
            always @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    flags_q[gi] <= 1'b0;
                end else if (set_vec[gi]) begin
                    flags_q[gi] <= 1'b1;
                end else if (clr_vec[gi]) begin
                    flags_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // interrupt line from enabled flags
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(flags_q & enables_q);
        end
    end

    assign irq_o = irq_q;

endmodule // iosi_top

`default_nettype wire
